/* File: design/pieb_bank.sv */
// pieb_bank: six peripheral interrupt enable registers and request combine
// assumes flags arrive from peripherals outside this clock, global bits likewise
//
// Functional notes
// - a set enable passes its flag; a clear enable blocks it
// - all enable bits read zero after reset
// - unimplemented bits read zero and ignore writes
// - third register bits 5 and 4 are read-only zero
// - small-memory variant lacks capcomp 10,9 and timer 7g,12,10,7 enables
// - first register bit map: parallel port down to timer1 overflow
// - second register bit map: osc fail down to timer3 gate
// - third register bit map: timer5 gate down to real-time clock
// - fourth register: capture/compare units 10 down to 3
// - fifth register bit map: timer7 gate down to timer4 match
// - sixth register: write done, comparators 3, 2, 1
// - without priority mode, global peripheral enable must also be set
// - each enable gates the same-position flag bit
module pieb_bank
  import pieb_pkg::*;
#(
  parameter bit SMALL_MEM = 1'b0
) (
  input  wire logic       i_clk,
  input  wire logic       i_rst_b,
  input  wire logic [2:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  output logic      [7:0] o_rdata,
  input  wire logic [7:0] i_flags1,
  input  wire logic [7:0] i_flags2,
  input  wire logic [7:0] i_flags3,
  input  wire logic [7:0] i_flags4,
  input  wire logic [7:0] i_flags5,
  input  wire logic [7:0] i_flags6,
  input  wire logic       i_global_peripheral_irq_en,
  input  wire logic       i_priority_mode_en,
  output logic            o_periph_irq_req,
  output logic            o_periph_irq_any
);

  // named enable bits, first register
  logic                     parallel_port_irq_en;
  logic                     converter_irq_en;
  logic                     serial1_rx_irq_en;
  logic                     serial1_tx_irq_en;
  logic                     sync_serial1_irq_en;
  logic                     timer1_gate_irq_en;
  logic                     timer2_match_irq_en;
  logic                     timer1_overflow_irq_en;

  // second register
  logic                     osc_fail_irq_en;
  logic                     sync_serial2_irq_en;
  logic                     bus_collision2_irq_en;
  logic                     bus_collision1_irq_en;
  logic                     voltage_detect_irq_en;
  logic                     timer3_overflow_irq_en;
  logic                     timer3_gate_irq_en;

  // third register
  logic                     timer5_gate_irq_en;
  logic                     serial2_rx_irq_en;
  logic                     serial2_tx_irq_en;
  logic                     charge_time_irq_en;
  logic                     capcomp2_irq_en;
  logic                     capcomp1_irq_en;
  logic                     real_time_clock_irq_en;

  // fourth register
  logic [7:0]               capcomp_10_to_3_irq_en;

  // fifth register
  logic                     timer7_gate_irq_en;
  logic                     timer12_match_irq_en;
  logic                     timer10_match_irq_en;
  logic                     timer8_match_irq_en;
  logic                     timer7_overflow_irq_en;
  logic                     timer6_match_irq_en;
  logic                     timer5_overflow_irq_en;
  logic                     timer4_match_irq_en;

  // sixth register
  logic                     nv_write_done_irq_en;
  logic                     comparator3_irq_en;
  logic                     comparator2_irq_en;
  logic                     comparator1_irq_en;

  // stored enables, write masks and the synchronised flags
  pieb_byte_t               en_reg      [PIEB_NUM_REGS];
  pieb_byte_t               wmask       [PIEB_NUM_REGS];
  pieb_byte_t               flags_async [PIEB_NUM_REGS];
  pieb_byte_t               flags_s     [PIEB_NUM_REGS];
  // enables rebuilt from the named bits, gaps forced to zero
  pieb_byte_t               en_view     [PIEB_NUM_REGS];
  logic [PIEB_NUM_REGS-1:0] reg_any;

  // combined request path
  logic [1:0]               glob_s;
  logic                     glob_en_s;
  logic                     pmode_s;
  logic                     any_pending;
  logic                     next_req;
  pieb_byte_t               stat_word;

  // write mask for an index, variant aware
  function automatic pieb_byte_t mask_of(input logic [2:0] idx);
    pieb_byte_t m;
    m = 8'h00;
    case (idx)
      PIEB_ADDR_EN1: m = PIEB_WMASK_EN1;
      PIEB_ADDR_EN2: m = PIEB_WMASK_EN2;
      PIEB_ADDR_EN3: m = PIEB_WMASK_EN3;
      PIEB_ADDR_EN4: m = SMALL_MEM ? (PIEB_WMASK_EN4 & ~PIEB_SMALL_DROP4) : PIEB_WMASK_EN4;
      PIEB_ADDR_EN5: m = SMALL_MEM ? (PIEB_WMASK_EN5 & ~PIEB_SMALL_DROP5) : PIEB_WMASK_EN5;
      PIEB_ADDR_EN6: m = PIEB_WMASK_EN6;
      default:       m = 8'h00;
    endcase
    return m;
  endfunction

  assign flags_async[0] = i_flags1;
  assign flags_async[1] = i_flags2;
  assign flags_async[2] = i_flags3;
  assign flags_async[3] = i_flags4;
  assign flags_async[4] = i_flags5;
  assign flags_async[5] = i_flags6;

  // one register per index: storage, sync and gating
  genvar g;
  generate
    for (g = 0; g < PIEB_NUM_REGS; g++) begin : g_reg
      assign wmask[g] = mask_of(3'(g));

      // masked write
      // a write lands at its strobe edge; gating sees it on the same edge
      always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
          en_reg[g] <= PIEB_RESET_VAL;
        end else if (i_wr && (i_addr == 3'(g))) begin
          en_reg[g] <= i_wdata & wmask[g];
        end
      end

      // flag levels come from other domains: two stages before any gating
      // so a flag change reaches the outputs three edges later
      pieb_sync #(
        .WIDTH (PIEB_DATA_W)
      ) u_sync (
        .i_clk   (i_clk),
        .i_rst_b (i_rst_b),
        .i_async (flags_async[g]),
        .o_sync  (flags_s[g])
      );

      pieb_gate u_gate (
        .i_flags   (flags_s[g]),
        .i_enables (en_view[g]),
        .o_pending (),
        .o_any     (reg_any[g])
      );
    end
  endgenerate

  // global control bits cross from outside
  pieb_sync #(
    .WIDTH (2)
  ) u_glob_sync (
    .i_clk   (i_clk),
    .i_rst_b (i_rst_b),
    .i_async ({i_priority_mode_en, i_global_peripheral_irq_en}),
    .o_sync  (glob_s)
  );

  assign {parallel_port_irq_en, converter_irq_en, serial1_rx_irq_en, serial1_tx_irq_en,
          sync_serial1_irq_en, timer1_gate_irq_en, timer2_match_irq_en,
          timer1_overflow_irq_en} = en_reg[0];
  assign {osc_fail_irq_en, sync_serial2_irq_en, bus_collision2_irq_en, bus_collision1_irq_en,
          voltage_detect_irq_en, timer3_overflow_irq_en, timer3_gate_irq_en} =
         {en_reg[1][7], en_reg[1][5:0]};
  assign {timer5_gate_irq_en, serial2_rx_irq_en, serial2_tx_irq_en, charge_time_irq_en,
          capcomp2_irq_en, capcomp1_irq_en, real_time_clock_irq_en} =
         {en_reg[2][7], en_reg[2][5:0]};
  assign capcomp_10_to_3_irq_en = en_reg[3];
  assign {timer7_gate_irq_en, timer12_match_irq_en, timer10_match_irq_en, timer8_match_irq_en,
          timer7_overflow_irq_en, timer6_match_irq_en, timer5_overflow_irq_en,
          timer4_match_irq_en} = en_reg[4];
  assign {nv_write_done_irq_en, comparator3_irq_en, comparator2_irq_en, comparator1_irq_en} =
         {en_reg[5][4], en_reg[5][2:0]};

  // named bits rebuilt into bytes: the map itself feeds gating and reads
  // gaps read zero
  // first register view
  assign en_view[0] = {parallel_port_irq_en,
                       converter_irq_en,
                       serial1_rx_irq_en,
                       serial1_tx_irq_en,
                       sync_serial1_irq_en,
                       timer1_gate_irq_en,
                       timer2_match_irq_en,
                       timer1_overflow_irq_en};

  // second register view, bit 6 absent
  assign en_view[1] = {osc_fail_irq_en,
                       1'h0,
                       sync_serial2_irq_en,
                       bus_collision2_irq_en,
                       bus_collision1_irq_en,
                       voltage_detect_irq_en,
                       timer3_overflow_irq_en,
                       timer3_gate_irq_en};

  // third register view, bit 6 absent
  assign en_view[2] = {timer5_gate_irq_en,
                       1'h0,
                       serial2_rx_irq_en,
                       serial2_tx_irq_en,
                       charge_time_irq_en,
                       capcomp2_irq_en,
                       capcomp1_irq_en,
                       real_time_clock_irq_en};

  // fourth register view
  assign en_view[3] = capcomp_10_to_3_irq_en;

  // fifth register view
  assign en_view[4] = {timer7_gate_irq_en,
                       timer12_match_irq_en,
                       timer10_match_irq_en,
                       timer8_match_irq_en,
                       timer7_overflow_irq_en,
                       timer6_match_irq_en,
                       timer5_overflow_irq_en,
                       timer4_match_irq_en};

  // sixth register view, top three and bit 3 absent
  assign en_view[5] = {3'h0,
                       nv_write_done_irq_en,
                       1'h0,
                       comparator3_irq_en,
                       comparator2_irq_en,
                       comparator1_irq_en};

  assign any_pending = |reg_any;

  // synchronised global bits by name
  assign glob_en_s = glob_s[0];
  assign pmode_s   = glob_s[1];

  // global enable needed unless priority mode
  assign next_req = any_pending && (pmode_s || glob_en_s);

  // status word, sampled by a read of the status index
  always_comb begin
    stat_word                  = PIEB_RESET_VAL;
    stat_word[PIEB_STAT_REQ]   = next_req;
    stat_word[PIEB_STAT_ANY]   = any_pending;
    stat_word[PIEB_STAT_GLOB]  = glob_en_s;
    stat_word[PIEB_STAT_PMODE] = pmode_s;
  end

  // gated request, registered
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      o_periph_irq_req <= 1'h0;
    end else begin
      o_periph_irq_req <= next_req;
    end
  end

  // ungated request, registered
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      o_periph_irq_any <= 1'h0;
    end else begin
      o_periph_irq_any <= any_pending;
    end
  end

  // read data, one cycle after the strobe, zero otherwise
  // the status read shows the values the output flops take next
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      o_rdata <= PIEB_RESET_VAL;
    end else if (i_rd && (i_addr == PIEB_ADDR_STAT)) begin
      o_rdata <= stat_word;
    end else if (i_rd && (i_addr <= PIEB_ADDR_EN6)) begin
      o_rdata <= en_view[i_addr];
    end else begin
      o_rdata <= PIEB_RESET_VAL;
    end
  end

endmodule

/* File: design/pieb_pkg.sv */
// pieb_pkg: constants for the peripheral interrupt enable bank
// assumes one 25 MHz clock and a plain register port with 8-bit data
package pieb_pkg;

  localparam int unsigned PIEB_NUM_REGS  = 6;
  localparam int unsigned PIEB_DATA_W    = 8;
  localparam int unsigned PIEB_ADDR_W    = 3;

  // register indices on the plain register port
  localparam logic [2:0] PIEB_ADDR_EN1 = 3'h0;
  localparam logic [2:0] PIEB_ADDR_EN2 = 3'h1;
  localparam logic [2:0] PIEB_ADDR_EN3 = 3'h2;
  localparam logic [2:0] PIEB_ADDR_EN4 = 3'h3;
  localparam logic [2:0] PIEB_ADDR_EN5 = 3'h4;
  localparam logic [2:0] PIEB_ADDR_EN6 = 3'h5;
  // status register: combined request view
  localparam logic [2:0] PIEB_ADDR_STAT = 3'h6;

  // reset value of every enable register
  localparam logic [7:0] PIEB_RESET_VAL = 8'h00;

  // writable bits, full-memory variant
  localparam logic [7:0] PIEB_WMASK_EN1 = 8'hFF;
  localparam logic [7:0] PIEB_WMASK_EN2 = 8'hBF;
  localparam logic [7:0] PIEB_WMASK_EN3 = 8'h8F;
  localparam logic [7:0] PIEB_WMASK_EN4 = 8'hFF;
  localparam logic [7:0] PIEB_WMASK_EN5 = 8'hFF;
  localparam logic [7:0] PIEB_WMASK_EN6 = 8'h17;

  // bits absent on the small-memory variant
  localparam logic [7:0] PIEB_SMALL_DROP4 = 8'hC0;
  localparam logic [7:0] PIEB_SMALL_DROP5 = 8'hE8;

  // status register field positions
  localparam int unsigned PIEB_STAT_REQ   = 0;
  localparam int unsigned PIEB_STAT_ANY   = 1;
  localparam int unsigned PIEB_STAT_GLOB  = 2;
  localparam int unsigned PIEB_STAT_PMODE = 3;

  typedef logic [7:0] pieb_byte_t;

endpackage

/* File: design/pieb_sync.sv */
// pieb_sync: two-flop synchroniser for a bus of levels
// assumes the inputs come from another domain or pins
module pieb_sync
  import pieb_pkg::*;
#(
  parameter int unsigned WIDTH = 8
) (
  input  wire logic             i_clk,
  input  wire logic             i_rst_b,
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);

  logic [WIDTH-1:0] stage1;

  // first stage feeds only the second
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      stage1 <= '0;
      o_sync <= '0;
    end else begin
      stage1 <= i_async;
      o_sync <= stage1;
    end
  end

endmodule

/* File: design/pieb_gate.sv */
// pieb_gate: masks one flag byte by its enable byte
// assumes flags and enables are both on the local clock
module pieb_gate
  import pieb_pkg::*;
(
  input  wire logic [7:0] i_flags,
  input  wire logic [7:0] i_enables,
  output logic      [7:0] o_pending,
  output logic            o_any
);

  // per-bit and, then or-reduce
  assign o_pending = i_flags & i_enables;
  assign o_any     = |o_pending;

endmodule

/* File: tb/pieb_bank_props.sv */
// pieb_bank_props: port-level checks of the enable bank
// assumes it is bound to every pieb_bank instance
module pieb_bank_props
  import pieb_pkg::*;
(
  input wire logic       i_clk,
  input wire logic       i_rst_b,
  input wire logic [2:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic       i_wr,
  input wire logic       i_rd,
  input wire logic [7:0] o_rdata,
  input wire logic [7:0] i_flags1,
  input wire logic [7:0] i_flags2,
  input wire logic [7:0] i_flags3,
  input wire logic [7:0] i_flags4,
  input wire logic [7:0] i_flags5,
  input wire logic [7:0] i_flags6,
  input wire logic       i_global_peripheral_irq_en,
  input wire logic       i_priority_mode_en,
  input wire logic       o_periph_irq_req,
  input wire logic       o_periph_irq_any
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  // no flag raised anywhere
  wire no_flag = ~|{i_flags1, i_flags2, i_flags3, i_flags4, i_flags5, i_flags6};
  wire glob_off = !i_global_peripheral_irq_en && !i_priority_mode_en;

  a_unmapped_read_zero: assert property ($past(i_rd) && $past(i_addr) == 3'h7 |-> o_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_reg2_gap_zero: assert property ($past(i_rd) && $past(i_addr) == PIEB_ADDR_EN2 |-> !o_rdata[6])
    else $error("second register gap bit set");
  a_reg3_ro_zero: assert property ($past(i_rd) && $past(i_addr) == PIEB_ADDR_EN3 |-> o_rdata[6:4] == 3'h0)
    else $error("third register fixed bits set");
  a_reg6_gap_zero: assert property ($past(i_rd) && $past(i_addr) == PIEB_ADDR_EN6 |-> (o_rdata & 8'hE8) == 8'h00)
    else $error("sixth register gap bits set");
  a_no_flag_quiet: assert property (no_flag [*3] |=> !o_periph_irq_any)
    else $error("request without any flag");
  a_req_needs_any: assert property (o_periph_irq_req |-> o_periph_irq_any)
    else $error("request without enabled flag");
  a_global_gate_off: assert property (glob_off [*3] |=> !o_periph_irq_req)
    else $error("request with global enable off");
  a_write_read_back: assert property (i_wr && i_addr == PIEB_ADDR_EN1 ##1 !i_wr
    ##1 i_rd && i_addr == PIEB_ADDR_EN1 |=> o_rdata == $past(i_wdata, 3))
    else $error("first register read back wrong");

  c_req_rise: cover property ($rose(o_periph_irq_req));
  c_read_set: cover property ($past(i_rd) && o_rdata != 8'h00);
  c_req_gated: cover property (o_periph_irq_any && !o_periph_irq_req);
endmodule

bind pieb_bank pieb_bank_props u_props (.*);

/* File: tb/pieb_periph.sv */
// pieb_periph: peripheral flag sources facing the enable bank
// assumes the bench raises events and clears flags on i_clk
module pieb_periph (
  input  wire logic            i_clk,
  input  wire logic            i_rst_b,
  input  wire logic            i_ev,
  input  wire logic [2:0]      i_k,
  input  wire logic [2:0]      i_n,
  input  wire logic            i_clr,
  output logic      [5:0][7:0] o_flags
);
  timeunit 1ns;
  timeprecision 1ns;
  // event sets one flag, software clears; a set beats a clear
  always @(posedge i_clk) begin
    if (!i_rst_b) begin
      o_flags <= '0;
    end else begin
      if (i_clr)
        o_flags <= '0;
      if (i_ev)
        o_flags[i_k][i_n] <= 1'b1;
    end
  end
endmodule

/* File: tb/tb.sv */
// tb: self-checking bench for the peripheral enable bank
// assumes the flag model and checker are compiled first
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import pieb_pkg::*;
  logic clk = 0, rst_b = 0, wr = 0, rd = 0, ev = 0, clr = 0, glob = 0, pmode = 0;
  logic [2:0] addr = 0, k = 0, n = 0;
  logic [7:0] wdata = 0, rdata, v, rdata_small, v_small;
  logic req, irq_any;
  logic [5:0][7:0] flags;
  int bad_count = 0, cmp_count = 0;
  pieb_byte_t wmask [6] = '{PIEB_WMASK_EN1, PIEB_WMASK_EN2, PIEB_WMASK_EN3, PIEB_WMASK_EN4, PIEB_WMASK_EN5,
                            PIEB_WMASK_EN6};
  // bits that the small-memory variant lacks
  pieb_byte_t drop [6] = '{8'h00, 8'h00, 8'h00, PIEB_SMALL_DROP4, PIEB_SMALL_DROP5, 8'h00};

  always #20 clk = ~clk;
  pieb_periph u_src (.i_clk(clk), .i_rst_b(rst_b), .i_ev(ev), .i_k(k), .i_n(n), .i_clr(clr), .o_flags(flags));
  pieb_bank dut (.i_clk(clk), .i_rst_b(rst_b), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
    .o_rdata(rdata), .i_flags1(flags[0]), .i_flags2(flags[1]), .i_flags3(flags[2]), .i_flags4(flags[3]),
    .i_flags5(flags[4]), .i_flags6(flags[5]), .i_global_peripheral_irq_en(glob),
    .i_priority_mode_en(pmode), .o_periph_irq_req(req), .o_periph_irq_any(irq_any));
  // small-memory variant on the same bus and flags
  pieb_bank #(.SMALL_MEM(1'h1)) dut_small (.i_clk(clk), .i_rst_b(rst_b), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr), .i_rd(rd), .o_rdata(rdata_small), .i_flags1(flags[0]), .i_flags2(flags[1]), .i_flags3(flags[2]),
    .i_flags4(flags[3]), .i_flags5(flags[4]), .i_flags6(flags[5]), .i_global_peripheral_irq_en(glob),
    .i_priority_mode_en(pmode), .o_periph_irq_req(), .o_periph_irq_any());

  task automatic summarize();
    if (bad_count == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // bus cycles start just after a rising edge
  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    wr <= 1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 0;
    @(posedge clk);
  endtask
  task automatic rd_reg(input logic [2:0] a);
    rd <= 1;
    addr <= a;
    @(posedge clk);
    rd <= 0;
    @(negedge clk);
    v = rdata;
    v_small = rdata_small;
    @(posedge clk);
  endtask
  // clear all flags, then raise one
  task automatic raise(input int kk, input int nn);
    clr <= 1;
    @(posedge clk);
    clr <= 0;
    ev <= 1;
    k <= kk[2:0];
    n <= nn[2:0];
    @(posedge clk);
    ev <= 0;
  endtask
  task automatic look(input logic ea, input logic eq);
    repeat (5) @(negedge clk);
    chk({7'h0, irq_any}, {7'h0, ea});
    chk({7'h0, req}, {7'h0, eq});
    @(posedge clk);
  endtask

  task automatic t_reset();
    for (int a = 0; a < 8; a++) begin
      rd_reg(a[2:0]);
      chk(v, 8'h00);
    end
  endtask
  task automatic t_masks();
    for (int a = 0; a < 6; a++)
      wr_reg(a[2:0], 8'hFF);
    for (int a = 0; a < 6; a++) begin
      rd_reg(a[2:0]);
      chk(v, wmask[a]);
      chk(v_small, wmask[a] & ~drop[a]);
    end
    wr_reg(PIEB_ADDR_EN1, 8'hA5);
    rd_reg(PIEB_ADDR_EN1);
    chk(v, 8'hA5);
  endtask
  task automatic t_gate();
    glob <= 1;
    for (int kk = 0; kk < 6; kk++)
      for (int nn = 0; nn < 8; nn++) begin
        raise(kk, nn);
        wr_reg(kk[2:0], 8'h01 << nn);
        look(wmask[kk][nn], wmask[kk][nn]);
        wr_reg(kk[2:0], wmask[kk] & ~(8'h01 << nn));
        look(0, 0);
      end
  endtask
  task automatic t_global();
    raise(0, 0);
    wr_reg(PIEB_ADDR_EN1, 8'h01);
    glob <= 0;
    look(1, 0);
    glob <= 1;
    look(1, 1);
    glob <= 0;
    pmode <= 1;
    look(1, 1);
  endtask

  initial begin
    repeat (2) @(posedge clk);
    rst_b <= 1;
    t_reset();
    t_masks();
    t_gate();
    t_global();
    summarize();
  end
  initial begin
    repeat (5000) @(posedge clk);
    bad_count++;
    summarize();
  end
endmodule
